// >>> ddg_bank.sv
// Divider and detector clock gating register bank
`timescale 1ns/100ps
`default_nettype none
`include "ddg_regs.svh"

// What this block does
// - Per-output-divider power bit, one powers up
// - Output divider runs only when gate zero
// - Feedback divider clock stops when bit one
// - Feedback calibration inhibited while bit one
// - Signal-loss detection per input while zero
// - Frequency-offset clocks gated, top bit reference
// - Frequency-offset divider clocks gated, same mapping
// - Two reserved byte registers read and write
// - Twelve-bit oscillator code across two addresses
// - Output drives only when route enable set
module ddg_bank (
   input  wire logic                         CLK,
   input  wire logic                         RST,
   input  wire ddg_pkg::ddg_addr_type        REG_ADDR,
   input  wire logic                         REG_WR,
   input  wire logic                         REG_RD,
   input  wire ddg_pkg::ddg_data_type        REG_WDATA,
   output ddg_pkg::ddg_data_type             REG_RDATA,
   output logic                              REG_RVALID,
   output logic [`DDG_NOUT-1:0]              OUT_DIV_RUN,
   output logic [`DDG_NOUT-1:0]              OUT_DIV_DRIVE,
   output logic                              FB_DIV_RUN,
   output logic                              FB_CAL_PERMIT,
   output logic [`DDG_NIN-1:0]               LOS_DET_RUN,
   output logic [`DDG_NOOF-1:0]              OOF_DET_RUN,
   output logic [`DDG_NOOF-1:0]              OOF_DIV_RUN,
   output logic [`DDG_CAL_W-1:0]             CAL_INHIBIT,
   output logic [`DDG_CAL_W-1:0]             CAL_FORCE,
   output logic [`DDG_CODE_W-1:0]            OSC_CAL_CODE,
   output ddg_pkg::ddg_data_type             UPD_SEQ_A,
   output ddg_pkg::ddg_data_type             UPD_SEQ_B
);
   import ddg_pkg::*;

   ddg_bank_type            st_reg;
   ddg_bank_type            st_next;
   logic [`DDG_NOUT-1:0]    div_drive;
   logic [`DDG_NDET-1:0]    det_run;

   // ****************************************
   // Address decode
   // ****************************************
   function automatic logic hit(input ddg_addr_type a,
                                input ddg_addr_type off);
      hit = (a == off);
   endfunction

   // ****************************************
   // Register write and read
   // ****************************************
   always_comb begin
      st_next        = st_reg;
      st_next.rvalid = REG_RD;
      st_next.rdata  = `DDG_RDATA_ZERO;
      if (REG_WR) begin
         if (hit(REG_ADDR, `DDG_OFF_ROUTE)) begin
            st_next.route_en = REG_WDATA[`DDG_NOUT-1:0];
         end
         if (hit(REG_ADDR, `DDG_OFF_POWER)) begin
            st_next.power_on = REG_WDATA[`DDG_NOUT-1:0];
         end
         if (hit(REG_ADDR, `DDG_OFF_RES_A)) begin
            st_next.res_a = REG_WDATA;
         end
         if (hit(REG_ADDR, `DDG_OFF_RES_B)) begin
            st_next.res_b = REG_WDATA;
         end
         if (hit(REG_ADDR, `DDG_OFF_LOS_GATE)) begin
            st_next.los_gate = REG_WDATA[`DDG_NIN-1:0];
         end
         if (hit(REG_ADDR, `DDG_OFF_OOF_GATE)) begin
            st_next.oof_gate = REG_WDATA[`DDG_NOOF-1:0];
         end
         if (hit(REG_ADDR, `DDG_OFF_OOF_DIV)) begin
            st_next.oof_div_gate = REG_WDATA[`DDG_NOOF-1:0];
         end
         if (hit(REG_ADDR, `DDG_OFF_CAL_OVR)) begin
            // Stored as written; keeping them zero is up to software
            st_next.cal_inhibit = REG_WDATA[`DDG_CAL_INH_LSB +: `DDG_CAL_W];
            st_next.cal_force   = REG_WDATA[`DDG_CAL_FRC_LSB +: `DDG_CAL_W];
         end
         if (hit(REG_ADDR, `DDG_OFF_DIV_GATE)) begin
            st_next.out_gate   = REG_WDATA[`DDG_NOUT-1:0];
            st_next.fb_gate    = REG_WDATA[`DDG_FB_GATE_BIT];
            st_next.fb_cal_inh = REG_WDATA[`DDG_FB_CAL_BIT];
         end
         if (hit(REG_ADDR, `DDG_OFF_CODE_LO)) begin
            st_next.cal_code[`DDG_CODE_LO_W-1:0] = REG_WDATA;
         end
         if (hit(REG_ADDR, `DDG_OFF_CODE_HI)) begin
            st_next.cal_code[`DDG_CODE_W-1:`DDG_CODE_LO_W] =
               REG_WDATA[`DDG_CODE_HI_W-1:0];
         end
      end
      if (REG_RD) begin
         // Reserved bits and unmapped addresses read as zero
         if (hit(REG_ADDR, `DDG_OFF_ROUTE)) begin
            st_next.rdata[`DDG_NOUT-1:0] = st_reg.route_en;
         end
         if (hit(REG_ADDR, `DDG_OFF_POWER)) begin
            st_next.rdata[`DDG_NOUT-1:0] = st_reg.power_on;
         end
         if (hit(REG_ADDR, `DDG_OFF_STATUS)) begin
            st_next.rdata[`DDG_NOUT-1:0] = div_drive;
         end
         if (hit(REG_ADDR, `DDG_OFF_RES_A)) begin
            st_next.rdata = st_reg.res_a;
         end
         if (hit(REG_ADDR, `DDG_OFF_RES_B)) begin
            st_next.rdata = st_reg.res_b;
         end
         if (hit(REG_ADDR, `DDG_OFF_LOS_GATE)) begin
            st_next.rdata[`DDG_NIN-1:0] = st_reg.los_gate;
         end
         if (hit(REG_ADDR, `DDG_OFF_OOF_GATE)) begin
            st_next.rdata[`DDG_NOOF-1:0] = st_reg.oof_gate;
         end
         if (hit(REG_ADDR, `DDG_OFF_OOF_DIV)) begin
            st_next.rdata[`DDG_NOOF-1:0] = st_reg.oof_div_gate;
         end
         if (hit(REG_ADDR, `DDG_OFF_CAL_OVR)) begin
            st_next.rdata[`DDG_CAL_INH_LSB +: `DDG_CAL_W] =
               st_reg.cal_inhibit;
            st_next.rdata[`DDG_CAL_FRC_LSB +: `DDG_CAL_W] = st_reg.cal_force;
         end
         if (hit(REG_ADDR, `DDG_OFF_DIV_GATE)) begin
            st_next.rdata[`DDG_NOUT-1:0]     = st_reg.out_gate;
            st_next.rdata[`DDG_FB_GATE_BIT]  = st_reg.fb_gate;
            st_next.rdata[`DDG_FB_CAL_BIT]   = st_reg.fb_cal_inh;
         end
         if (hit(REG_ADDR, `DDG_OFF_CODE_LO)) begin
            st_next.rdata = st_reg.cal_code[`DDG_CODE_LO_W-1:0];
         end
         if (hit(REG_ADDR, `DDG_OFF_CODE_HI)) begin
            st_next.rdata[`DDG_CODE_HI_W-1:0] =
               st_reg.cal_code[`DDG_CODE_W-1:`DDG_CODE_LO_W];
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         st_reg.route_en     <= `DDG_RST_ROUTE;
         st_reg.power_on     <= `DDG_RST_POWER;
         st_reg.res_a        <= `DDG_RST_RES;
         st_reg.res_b        <= `DDG_RST_RES;
         st_reg.los_gate     <= `DDG_RST_LOS;
         st_reg.oof_gate     <= `DDG_RST_OOF;
         st_reg.oof_div_gate <= `DDG_RST_OOF;
         st_reg.cal_inhibit  <= `DDG_RST_CAL;
         st_reg.cal_force    <= `DDG_RST_CAL;
         st_reg.out_gate     <= `DDG_RST_POWER;
         st_reg.fb_gate      <= `DDG_RST_FB;
         st_reg.fb_cal_inh   <= `DDG_RST_FB;
         st_reg.cal_code     <= `DDG_RST_CODE;
         st_reg.rdata        <= `DDG_RDATA_ZERO;
         st_reg.rvalid       <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ****************************************
   // Clock enables
   // ****************************************
   ddg_chan_gate #(
      .N          (`DDG_NOUT)
   ) u_out_gate (
      .clk        (CLK),
      .rst        (RST),
      .gate_bits  (st_reg.out_gate),
      .power_bits (st_reg.power_on),
      .route_bits (st_reg.route_en),
      .run        (OUT_DIV_RUN),
      .drive      (div_drive)
   );

   // Detectors have no power or route bit, so only the gates matter
   ddg_chan_gate #(
      .N          (`DDG_NDET)
   ) u_det_gate (
      .clk        (CLK),
      .rst        (RST),
      .gate_bits  ({st_reg.oof_div_gate, st_reg.oof_gate,
                    st_reg.los_gate}),
      .power_bits ({`DDG_NDET{1'b1}}),
      .route_bits ({`DDG_NDET{1'b1}}),
      .run        (det_run),
      .drive      ()
   );

   ddg_fb_ctrl u_fb (
      .clk        (CLK),
      .rst        (RST),
      .fb_gate    (st_reg.fb_gate),
      .fb_cal_inh (st_reg.fb_cal_inh),
      .fb_run     (FB_DIV_RUN),
      .fb_cal_ok  (FB_CAL_PERMIT)
   );

   assign LOS_DET_RUN   = det_run[`DDG_NIN-1:0];
   assign OOF_DET_RUN   = det_run[`DDG_NIN +: `DDG_NOOF];
   assign OOF_DIV_RUN   = det_run[`DDG_NIN+`DDG_NOOF +: `DDG_NOOF];
   assign OUT_DIV_DRIVE = div_drive;
   assign CAL_INHIBIT   = st_reg.cal_inhibit;
   assign CAL_FORCE     = st_reg.cal_force;
   assign OSC_CAL_CODE  = st_reg.cal_code;
   assign UPD_SEQ_A     = st_reg.res_a;
   assign UPD_SEQ_B     = st_reg.res_b;
   assign REG_RDATA     = st_reg.rdata;
   assign REG_RVALID    = st_reg.rvalid;

endmodule
`default_nettype wire

// >>> ddg_regs.svh
// Register offsets, field layouts and reset values of the divider gate bank
`ifndef DDG_REGS_SVH
`define DDG_REGS_SVH

// ****************************************
// Address and data widths
// ****************************************
`define DDG_ADDR_W          16
`define DDG_DATA_W          8

// ****************************************
// Register offsets
// ****************************************
`define DDG_OFF_ROUTE       16'h0a03
`define DDG_OFF_POWER       16'h0a05
`define DDG_OFF_STATUS      16'h0a06
`define DDG_OFF_RES_A       16'h0b24
`define DDG_OFF_RES_B       16'h0b25
`define DDG_OFF_LOS_GATE    16'h0b46
`define DDG_OFF_OOF_GATE    16'h0b47
`define DDG_OFF_OOF_DIV     16'h0b48
`define DDG_OFF_CAL_OVR     16'h0b49
`define DDG_OFF_DIV_GATE    16'h0b4a
`define DDG_OFF_CODE_LO     16'h0b57
`define DDG_OFF_CODE_HI     16'h0b58

// ****************************************
// Field widths and positions
// ****************************************
`define DDG_NOUT            5
`define DDG_NIN             4
`define DDG_NOOF            5
`define DDG_NDET            14
`define DDG_CAL_W           2
`define DDG_CODE_W          12
`define DDG_CODE_LO_W       8
`define DDG_CODE_HI_W       4
`define DDG_CAL_INH_LSB     0
`define DDG_CAL_FRC_LSB     2
`define DDG_FB_GATE_BIT     5
`define DDG_FB_CAL_BIT      6

// ****************************************
// Reset values
// ****************************************
`define DDG_RST_ROUTE       5'h00
`define DDG_RST_POWER       5'h00
`define DDG_RST_RES         8'h00
`define DDG_RST_LOS         4'h0
`define DDG_RST_OOF         5'h00
`define DDG_RST_CAL         2'h0
`define DDG_RST_FB          1'b0
`define DDG_RST_CODE        12'h000
`define DDG_RDATA_ZERO      8'h00

`endif

// >>> ddg_pkg.sv
// Types shared by the divider gate bank modules
`default_nettype none
`include "ddg_regs.svh"

package ddg_pkg;

   typedef logic [`DDG_ADDR_W-1:0] ddg_addr_type;
   typedef logic [`DDG_DATA_W-1:0] ddg_data_type;

   // ****************************************
   // Register bank state
   // ****************************************
   typedef struct packed {
      logic [`DDG_NOUT-1:0]   route_en;
      logic [`DDG_NOUT-1:0]   power_on;
      ddg_data_type           res_a;
      ddg_data_type           res_b;
      logic [`DDG_NIN-1:0]    los_gate;
      logic [`DDG_NOOF-1:0]   oof_gate;
      logic [`DDG_NOOF-1:0]   oof_div_gate;
      logic [`DDG_CAL_W-1:0]  cal_inhibit;
      logic [`DDG_CAL_W-1:0]  cal_force;
      logic [`DDG_NOUT-1:0]   out_gate;
      logic                   fb_gate;
      logic                   fb_cal_inh;
      logic [`DDG_CODE_W-1:0] cal_code;
      ddg_data_type           rdata;
      logic                   rvalid;
   } ddg_bank_type;

endpackage
`default_nettype wire

// >>> ddg_chan_gate.sv
// Per-channel clock enable: runs where powered and not gated
`timescale 1ns/100ps
`default_nettype none

module ddg_chan_gate #(
   parameter int N = 5
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [N-1:0] gate_bits,
   input  wire logic [N-1:0] power_bits,
   input  wire logic [N-1:0] route_bits,
   output logic      [N-1:0] run,
   output logic      [N-1:0] drive
);

   typedef struct packed {
      logic [N-1:0] run;
      logic [N-1:0] drive;
   } ddg_chan_type;

   ddg_chan_type st_reg;
   ddg_chan_type st_next;

   // ****************************************
   // Channel enables
   // ****************************************
   always_comb begin
      st_next = st_reg;
      for (int i = 0; i < N; i++) begin
         st_next.run[i]   = power_bits[i] & ~gate_bits[i];
         // A channel only reaches its driver once routed as well
         st_next.drive[i] = power_bits[i] & ~gate_bits[i] & route_bits[i];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign run   = st_reg.run;
   assign drive = st_reg.drive;

endmodule
`default_nettype wire

// >>> ddg_fb_ctrl.sv
// Feedback divider run and calibration permit
`timescale 1ns/100ps
`default_nettype none

module ddg_fb_ctrl (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       fb_gate,
   input  wire logic       fb_cal_inh,
   output logic            fb_run,
   output logic            fb_cal_ok
);

   typedef struct packed {
      logic run;
      logic cal_ok;
   } ddg_fb_type;

   ddg_fb_type st_reg;
   ddg_fb_type st_next;

   always_comb begin
      st_next        = st_reg;
      st_next.run    = ~fb_gate;
      st_next.cal_ok = ~fb_cal_inh;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign fb_run    = st_reg.run;
   assign fb_cal_ok = st_reg.cal_ok;

endmodule
`default_nettype wire

// >>> ddg_bank_props.sv
// Port checks for the divider gate bank
`timescale 1ns/100ps
`default_nettype none
`include "ddg_regs.svh"
module ddg_bank_props (
   input wire logic                  CLK,
   input wire logic                  RST,
   input wire ddg_pkg::ddg_addr_type REG_ADDR,
   input wire logic                  REG_WR,
   input wire logic                  REG_RD,
   input wire ddg_pkg::ddg_data_type REG_WDATA,
   input wire logic                  REG_RVALID,
   input wire logic [4:0]            OUT_DIV_RUN,
   input wire logic [4:0]            OUT_DIV_DRIVE,
   input wire logic                  FB_DIV_RUN,
   input wire logic                  FB_CAL_PERMIT,
   input wire logic [3:0]            LOS_DET_RUN,
   input wire logic [4:0]            OOF_DET_RUN,
   input wire logic [4:0]            OOF_DIV_RUN,
   input wire logic [11:0]           OSC_CAL_CODE,
   input wire ddg_pkg::ddg_data_type UPD_SEQ_A,
   input wire ddg_pkg::ddg_data_type UPD_SEQ_B
);
   import ddg_pkg::*;
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   // ****************************************
   // Derived enables land two edges after the strobe
   // ****************************************
   sequence s_wr(logic [15:0] a);
      REG_WR && REG_ADDR == a;
   endsequence
   a_read_answer: assert property (REG_RD |=> REG_RVALID)
      else $error("read not answered");
   a_valid_cause: assert property (REG_RVALID |-> $past(REG_RD))
      else $error("stray read valid");
   a_seq_a_store: assert property (s_wr(`DDG_OFF_RES_A) |=>
      UPD_SEQ_A == $past(REG_WDATA)) else $error("seq a not stored");
   a_seq_b_store: assert property (s_wr(`DDG_OFF_RES_B) |=>
      UPD_SEQ_B == $past(REG_WDATA)) else $error("seq b not stored");
   a_code_low: assert property (s_wr(`DDG_OFF_CODE_LO) |=>
      OSC_CAL_CODE[7:0] == $past(REG_WDATA)) else $error("code low");
   a_code_high: assert property (s_wr(`DDG_OFF_CODE_HI) |=>
      OSC_CAL_CODE[11:8] == $past(REG_WDATA[3:0])
      && $stable(OSC_CAL_CODE[7:0])) else $error("code high");
   a_power_off: assert property (s_wr(`DDG_OFF_POWER) |-> ##2
      (OUT_DIV_RUN & ~$past(REG_WDATA[4:0], 2)) == 5'h00)
      else $error("unpowered divider runs");
   a_gate_stops: assert property (s_wr(`DDG_OFF_DIV_GATE) |-> ##2
      (OUT_DIV_RUN & $past(REG_WDATA[4:0], 2)) == 5'h00)
      else $error("gated divider runs");
   a_fb_control: assert property (s_wr(`DDG_OFF_DIV_GATE) |-> ##2
      FB_DIV_RUN == !$past(REG_WDATA[5], 2)
      && FB_CAL_PERMIT == !$past(REG_WDATA[6], 2))
      else $error("feedback control");
   a_route_qual: assert property (s_wr(`DDG_OFF_ROUTE) |-> ##2
      (OUT_DIV_DRIVE & ~$past(REG_WDATA[4:0], 2)) == 5'h00)
      else $error("unrouted output drives");
   a_los_run: assert property (s_wr(`DDG_OFF_LOS_GATE) |-> ##2
      LOS_DET_RUN == ~$past(REG_WDATA[3:0], 2)) else $error("los run");
   a_oof_run: assert property (s_wr(`DDG_OFF_OOF_GATE) |-> ##2
      OOF_DET_RUN == ~$past(REG_WDATA[4:0], 2)) else $error("oof run");
   a_oof_div_run: assert property (s_wr(`DDG_OFF_OOF_DIV) |-> ##2
      OOF_DIV_RUN == ~$past(REG_WDATA[4:0], 2)) else $error("oof div");
endmodule
bind ddg_bank ddg_bank_props u_props (.CLK(CLK), .RST(RST),
   .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
   .REG_WDATA(REG_WDATA), .REG_RVALID(REG_RVALID),
   .OUT_DIV_RUN(OUT_DIV_RUN), .OUT_DIV_DRIVE(OUT_DIV_DRIVE),
   .FB_DIV_RUN(FB_DIV_RUN), .FB_CAL_PERMIT(FB_CAL_PERMIT),
   .LOS_DET_RUN(LOS_DET_RUN), .OOF_DET_RUN(OOF_DET_RUN),
   .OOF_DIV_RUN(OOF_DIV_RUN), .OSC_CAL_CODE(OSC_CAL_CODE),
   .UPD_SEQ_A(UPD_SEQ_A), .UPD_SEQ_B(UPD_SEQ_B));
`default_nettype wire

// >>> ddg_bank_test.sv
// Self-checking bench for the divider gate bank
`timescale 1ns/100ps
`default_nettype none
`include "ddg_regs.svh"
module ddg_bank_test;
   import ddg_pkg::*;
   logic         clk, rst, wr, rd, rvalid, fb_run, fb_cal;
   ddg_addr_type addr;
   ddg_data_type wdata, rdata, seq_a, seq_b, d;
   logic [4:0]   div_run, div_drv, oof_run, oofd_run;
   logic [3:0]   los_run;
   logic [1:0]   cal_inh, cal_frc;
   logic [11:0]  code;
   int           n_mismatch, num_checks;
   ddg_addr_type offs [11] = '{`DDG_OFF_ROUTE, `DDG_OFF_POWER,
      `DDG_OFF_RES_A, `DDG_OFF_RES_B, `DDG_OFF_LOS_GATE, `DDG_OFF_OOF_GATE,
      `DDG_OFF_OOF_DIV, `DDG_OFF_CAL_OVR, `DDG_OFF_DIV_GATE,
      `DDG_OFF_CODE_LO, `DDG_OFF_CODE_HI};
   ddg_data_type msk [11] = '{8'h1f, 8'h1f, 8'hff, 8'hff, 8'h0f, 8'h1f,
      8'h1f, 8'h0f, 8'h7f, 8'hff, 8'h0f};
   ddg_bank DUT (.CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WR(wr),
      .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata),
      .REG_RVALID(rvalid), .OUT_DIV_RUN(div_run), .OUT_DIV_DRIVE(div_drv),
      .FB_DIV_RUN(fb_run), .FB_CAL_PERMIT(fb_cal), .LOS_DET_RUN(los_run),
      .OOF_DET_RUN(oof_run), .OOF_DIV_RUN(oofd_run), .CAL_INHIBIT(cal_inh),
      .CAL_FORCE(cal_frc), .OSC_CAL_CODE(code), .UPD_SEQ_A(seq_a),
      .UPD_SEQ_B(seq_b));
   // ****************************************
   // Shared tasks
   // ****************************************
   task report_and_stop;
      if (n_mismatch == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task chk(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task wrt(input ddg_addr_type a, input ddg_data_type v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   // Derived enables need one more edge than the stored value
   task wst(input ddg_addr_type a, input ddg_data_type v);
      wrt(a, v);
      @(posedge clk);
      #1;
   endtask
   task rdd(input ddg_addr_type a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      if (rvalid !== 1'b1) begin
         n_mismatch++;
         report_and_stop;
      end
      d = rdata;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task t_reset;
      for (int i = 0; i < 11; i++) begin
         rdd(offs[i]);
         chk(d, 8'h00);
      end
      chk({los_run, oof_run, oofd_run}, 14'h3fff);
      chk({div_run, fb_run, fb_cal}, 7'h03);
   endtask
   task t_rw;
      // Each bank offset but the read-only status is written and read back; the unmapped 16'h0b50 is written and reads zero
      for (int i = 0; i < 11; i++) begin
         wrt(offs[i], 8'hff);
         rdd(offs[i]);
         chk(d, msk[i]);
         wrt(offs[i], 8'h00);
      end
      wrt(16'h0b50, 8'hff);
      rdd(16'h0b50);
      chk(d, 8'h00);
      @(posedge clk);
      #1;
      chk({rvalid, rdata}, 9'h000);
   endtask
   task t_outdiv;
      wrt(`DDG_OFF_POWER, 8'h15);
      wrt(`DDG_OFF_DIV_GATE, 8'h01);
      wst(`DDG_OFF_ROUTE, 8'h1f);
      chk(div_run, 5'h14);
      chk(div_drv, 5'h14);
      wst(`DDG_OFF_ROUTE, 8'h04);
      chk(div_drv, 5'h04);
      rdd(`DDG_OFF_STATUS);
      chk(d, 8'h04);
      wst(`DDG_OFF_DIV_GATE, 8'h20);
      chk({div_run, fb_run, fb_cal}, 7'h55);
      wst(`DDG_OFF_DIV_GATE, 8'h40);
      chk({fb_run, fb_cal}, 2'h2);
   endtask
   task t_detect;
      wst(`DDG_OFF_LOS_GATE, 8'hf5);
      chk(los_run, 4'ha);
      wst(`DDG_OFF_OOF_GATE, 8'h10);
      chk(oof_run, 5'h0f);
      wst(`DDG_OFF_OOF_DIV, 8'h03);
      chk(oofd_run, 5'h1c);
   endtask
   task t_code;
      wrt(`DDG_OFF_CODE_LO, 8'h3c);
      wrt(`DDG_OFF_CODE_HI, 8'ha5);
      chk(code, 12'h53c);
      wrt(`DDG_OFF_CODE_LO, 8'hc3);
      chk(code, 12'h5c3);
      wrt(`DDG_OFF_CAL_OVR, 8'h09);
      chk({cal_inh, cal_frc}, 4'h6);
      // Overrides go back to zero before normal operation resumes
      wrt(`DDG_OFF_CAL_OVR, 8'h00);
      chk({cal_inh, cal_frc}, 4'h0);
   endtask
   // Write and read together: the read sees the value before the write
   task t_order;
      wrt(`DDG_OFF_RES_B, 8'h33);
      @(posedge clk);
      addr <= `DDG_OFF_RES_B;
      wdata <= 8'h5a;
      wr <= 1'b1;
      rd <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
      chk({rvalid, rdata}, 9'h133);
      chk(seq_b, 8'h5a);
      wrt(`DDG_OFF_RES_A, 8'hc6);
      chk(seq_a, 8'hc6);
   endtask
   task t_midreset;
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      #1;
      chk({los_run, seq_b}, 12'h000);
      @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk(los_run, 4'hf);
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      #500000;
      n_mismatch++;
      report_and_stop;
   end
   initial begin
      {rst, wr, rd, addr, wdata} = 27'h4000000;
      n_mismatch = 0;
      num_checks = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_rw;
      t_outdiv;
      t_detect;
      t_code;
      t_order;
      t_midreset;
      report_and_stop;
   end
endmodule
`default_nettype wire
